/* File: core/nfhc_pkg.sv */
package nfhc_pkg;
  // ----------------------------------------
  // Commands
  // ----------------------------------------
  localparam logic [7:0] CMD_READ_SETUP = 8'h00;
  localparam logic [7:0] CMD_READ_CONFIRM = 8'h30;
  localparam logic [7:0] CMD_DATA_INPUT = 8'h80;
  localparam logic [7:0] CMD_PROGRAM_CONFIRM = 8'h10;
  localparam logic [7:0] CMD_PLANE_CONFIRM = 8'h11;
  localparam logic [7:0] CMD_PLANE_DATA_INPUT = 8'h81;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_RESET = 8'hFF;
  // ----------------------------------------
  // Page geometry
  // ----------------------------------------
  localparam int PAGE_BYTES = 2112;
  localparam int MAIN_BYTES = 2048;
  localparam int SECTOR_MAIN = 512;
  localparam int SECTOR_SPARE = 16;
  localparam int SECTOR_BYTES = 528;
  localparam int NUM_SECTORS = 4;
  localparam int ADDR_CYCLES = 5;
  localparam int COL_W = 12;
  localparam int ROW_W = 17;
  localparam int PAGE_IN_BLOCK_W = 6;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_PS = 4000;
  localparam int WE_LOW_NS = 25;
  localparam int WE_HIGH_NS = 20;
  localparam int WB_NS = 100;
  localparam int WE_LOW_CYC = (WE_LOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int WE_HIGH_CYC = (WE_HIGH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int WB_CYC = (WB_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CELL_TO_BUFFER_TIME_US = 25;
  localparam int CELL_TO_BUFFER_CYC = CELL_TO_BUFFER_TIME_US * 1000000 / CLK_PERIOD_PS;
  localparam int PLANE_DUMMY_BUSY_TIME_NS = 1000;
  localparam int PLANE_DUMMY_BUSY_CYC = PLANE_DUMMY_BUSY_TIME_NS * 1000 / CLK_PERIOD_PS;
  localparam int RESET_STATE_CYC = 1;
  // ----------------------------------------
  // Operations
  // ----------------------------------------
  typedef enum logic [2:0] {
    NFHC_OP_READ = 3'b000,
    NFHC_OP_PROGRAM = 3'b001,
    NFHC_OP_PLANE_FIRST = 3'b010,
    NFHC_OP_PLANE_SECOND = 3'b011,
    NFHC_OP_STATUS = 3'b100,
    NFHC_OP_RESET = 3'b101
  } nfhc_op_t;
endpackage

/* File: core/nfhc_bus_cycle.sv */
`timescale 1ns/1ps
`default_nettype none
// Drives one strobed bus cycle on the device pins: a write of cmd/addr/data, or a read.
module nfhc_bus_cycle
  import nfhc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic start,
  input wire logic is_read,
  input wire logic [7:0] wdata,
  output logic done,
  output logic [7:0] rdata,
  output logic strobe_n,
  output logic [7:0] io_out,
  output logic io_oe,
  input wire logic [7:0] io_in_sync
);
  typedef enum logic [1:0] {
    NFHC_BC_IDLE = 2'b00,
    NFHC_BC_LOW = 2'b01,
    NFHC_BC_HIGH = 2'b10
  } nfhc_bc_t;

  nfhc_bc_t state;
  logic [3:0] cnt;
  logic rd;

  wire low_end = (state == NFHC_BC_LOW) && (cnt == 4'(WE_LOW_CYC + 2 - 1));
  wire high_end = (state == NFHC_BC_HIGH) && (cnt == 4'(WE_HIGH_CYC - 1));
  assign done = high_end;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state <= NFHC_BC_IDLE;
      cnt <= 4'h0;
      rd <= 1'b0;
      strobe_n <= 1'b1;
      io_out <= 8'h00;
      io_oe <= 1'b0;
      rdata <= 8'h00;
    end else begin
      unique case (state)
        NFHC_BC_IDLE: begin
          if (start) begin
            state <= NFHC_BC_LOW;
            cnt <= 4'h0;
            rd <= is_read;
            strobe_n <= 1'b0;
            io_out <= wdata;
            io_oe <= !is_read;
          end
        end
        NFHC_BC_LOW: begin
          // Two extra cycles cover the read-path synchroniser delay
          cnt <= cnt + 4'h1;
          if (low_end) begin
            state <= NFHC_BC_HIGH;
            cnt <= 4'h0;
            strobe_n <= 1'b1;
            if (rd) rdata <= io_in_sync;
          end
        end
        NFHC_BC_HIGH: begin
          cnt <= cnt + 4'h1;
          if (high_end) begin
            state <= NFHC_BC_IDLE;
            io_oe <= 1'b0;
          end
        end
      endcase
    end
  end
endmodule // nfhc_bus_cycle
`default_nettype wire

/* File: core/nfhc_host.sv */
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Copy-back checks hold only if whole pages or whole 528-byte sectors are programmed.
// - Before copy-back, a sector may be rewritten only whole and only once.
// - Sector k: columns 512k..512k+511 and 2048+16k..2048+16k+15.
// - Pages in a block are programmed in strictly ascending order (the code checks order only within the block programmed most recently).
// - Never program pages of a block out of ascending order.
// - The first programmed page sets the floor; it need not be page 0.
// - Address is five cycles: col 0-7, col 8-11, row 12-19, 20-27, 28.
// - Between 11h and 81h only 70h or FFh may be issued.
// - On failure, copy pages before n to a free block, then page n.
// - Record a failed block and never erase or program it again (the code refuses only the block that failed most recently).
// - Read is 00h, five address cycles, 30h, then busy up to 25 us.
// - Program loading starts with 80h then five address cycles.
module nfhc_host
  import nfhc_pkg::*;
#(
  parameter int BUSY_TIMEOUT_CYC = CELL_TO_BUFFER_CYC
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [2:0] req_op,
  input wire logic [COL_W-1:0] req_col,
  input wire logic [ROW_W-1:0] req_row,
  input wire logic [11:0] req_len,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [7:0] wr_data,
  output logic rd_valid,
  output logic [7:0] rd_data,
  output logic op_done,
  output logic op_error,
  output logic [7:0] op_status,
  output logic nand_cle,
  output logic nand_ale,
  output logic nand_ce_n,
  output logic nand_we_n,
  output logic nand_re_n,
  output logic [7:0] nand_io_out,
  output logic nand_io_oe,
  input wire logic [7:0] nand_io_in,
  input wire logic nand_rb
);
  // ----------------------------------------
  // Sequencer states
  // ----------------------------------------
  typedef enum logic [3:0] {
    NFHC_IDLE = 4'b0000,
    NFHC_CMD1 = 4'b0001,
    NFHC_ADDR = 4'b0010,
    NFHC_WDATA = 4'b0011,
    NFHC_CMD2 = 4'b0100,
    NFHC_WB = 4'b0101,
    NFHC_BUSY = 4'b0110,
    NFHC_RDATA = 4'b0111,
    NFHC_STAT = 4'b1000,
    NFHC_DONE = 4'b1001
  } nfhc_state_t;

  nfhc_state_t state;
  nfhc_op_t op;
  logic [COL_W-1:0] col;
  logic [ROW_W-1:0] row;
  logic [11:0] remain;
  logic [2:0] addr_idx;
  logic [22:0] wait_cnt;
  logic plane_open;
  logic [ROW_W-PAGE_IN_BLOCK_W-1:0] last_block;
  logic [PAGE_IN_BLOCK_W-1:0] last_page;
  logic last_valid;
  logic [ROW_W-PAGE_IN_BLOCK_W-1:0] bad_block;
  logic bad_valid;
  logic err;
  logic [7:0] io_sync1, io_sync2;
  logic rb_sync1, rb_sync2;
  logic bc_start, bc_read, bc_done;
  logic [7:0] bc_wdata, bc_rdata;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    io_sync1 <= nand_io_in;
    io_sync2 <= io_sync1;
    rb_sync1 <= nand_rb;
    rb_sync2 <= rb_sync1;
  end

  // ----------------------------------------
  // Request checks
  // ----------------------------------------
  // Only whole pages or whole sectors keep the on-chip check codes valid
  function automatic logic len_ok(input logic [COL_W-1:0] c, input logic [11:0] n);
    logic sec_main, sec_spare;
    sec_main = (c[8:0] == 9'h000) && (c < 12'(MAIN_BYTES));
    sec_spare = (c >= 12'(MAIN_BYTES)) && (c < 12'(PAGE_BYTES)) && (c[3:0] == 4'h0);
    len_ok = ((c == 12'h000) && (n == 12'(PAGE_BYTES)))
          || (sec_main && (n == 12'(SECTOR_MAIN)))
          || (sec_spare && (n == 12'(SECTOR_SPARE)));
  endfunction

  wire [ROW_W-PAGE_IN_BLOCK_W-1:0] req_block = req_row[ROW_W-1:PAGE_IN_BLOCK_W];
  wire [PAGE_IN_BLOCK_W-1:0] req_page = req_row[PAGE_IN_BLOCK_W-1:0];
  function automatic logic prog_op(input logic [2:0] o);
    prog_op = (o == NFHC_OP_PROGRAM) || (o == NFHC_OP_PLANE_FIRST)
           || (o == NFHC_OP_PLANE_SECOND);
  endfunction

  wire is_prog = prog_op(req_op);
  // A new block restarts the ascending run at whichever page comes first
  wire order_bad = is_prog && last_valid && (req_block == last_block)
                && (req_page <= last_page);
  // While a plane is open only status, reset or the second plane may go
  wire plane_bad = plane_open && (req_op != NFHC_OP_PLANE_SECOND)
                && (req_op != NFHC_OP_STATUS) && (req_op != NFHC_OP_RESET);
  wire shape_bad = is_prog && !len_ok(req_col, req_len);
  // Only the block that failed most recently is refused for programming
  wire bad_hit = is_prog && bad_valid && (req_block == bad_block);
  wire reject = order_bad || plane_bad || shape_bad || bad_hit;
  wire accept = req_valid && (state == NFHC_IDLE);

  // ----------------------------------------
  // Pin cycle selection
  // ----------------------------------------
  wire [7:0] addr_byte = (addr_idx == 3'd0) ? col[7:0] :
                         (addr_idx == 3'd1) ? {4'h0, col[11:8]} :
                         (addr_idx == 3'd2) ? row[7:0] :
                         (addr_idx == 3'd3) ? row[15:8] : {7'h00, row[16]};
  wire [7:0] cmd1 = (op == NFHC_OP_READ) ? CMD_READ_SETUP :
                    (op == NFHC_OP_PLANE_SECOND) ? CMD_PLANE_DATA_INPUT :
                    (op == NFHC_OP_STATUS) ? CMD_STATUS :
                    (op == NFHC_OP_RESET) ? CMD_RESET : CMD_DATA_INPUT;
  wire [7:0] cmd2 = (op == NFHC_OP_READ) ? CMD_READ_CONFIRM :
                    (op == NFHC_OP_PLANE_FIRST) ? CMD_PLANE_CONFIRM : CMD_PROGRAM_CONFIRM;
  wire st_wr = (state == NFHC_WDATA);
  wire st_rd = (state == NFHC_RDATA) || (state == NFHC_STAT);
  assign bc_read = st_rd;
  assign bc_wdata = (state == NFHC_CMD1) ? cmd1 : (state == NFHC_CMD2) ? cmd2 :
                    (state == NFHC_ADDR) ? addr_byte : wr_data;
  wire cycle_open = (state == NFHC_CMD1) || (state == NFHC_ADDR) || (state == NFHC_CMD2)
                 || st_rd;
  logic bc_busy;
  logic cycle_strobe_n;
  assign bc_start = !bc_busy && (cycle_open || (st_wr && wr_valid));
  assign wr_ready = st_wr && !bc_busy;
  assign req_ready = (state == NFHC_IDLE);
  wire last_xfer = (remain == 12'h001);
  wire timeout = (wait_cnt == 23'(BUSY_TIMEOUT_CYC));

  nfhc_bus_cycle nfhc_bus_cycle_i (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .start(bc_start),
    .is_read(bc_read),
    .wdata(bc_wdata),
    .done(bc_done),
    .rdata(bc_rdata),
    .strobe_n(cycle_strobe_n),
    .io_out(nand_io_out),
    .io_oe(nand_io_oe),
    .io_in_sync(io_sync2)
  );

  // Write strobe and read strobe share the bus-cycle low phase
  wire strobe_low = !cycle_strobe_n;
  assign nand_we_n = !(strobe_low && !st_rd);
  assign nand_re_n = !(strobe_low && st_rd);
  // Chip select is released between data bytes; the device keeps its buffer
  assign nand_ce_n = (state == NFHC_IDLE) || (state == NFHC_DONE)
                  || ((st_wr || state == NFHC_RDATA) && !bc_busy);
  assign nand_cle = (state == NFHC_CMD1) || (state == NFHC_CMD2);
  assign nand_ale = (state == NFHC_ADDR);

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      bc_busy <= 1'b0;
    end else begin
      if (bc_start) bc_busy <= 1'b1;
      else if (bc_done) bc_busy <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state <= NFHC_IDLE;
      op <= NFHC_OP_READ;
      col <= '0;
      row <= '0;
      remain <= 12'h000;
      addr_idx <= 3'd0;
      wait_cnt <= 23'h0;
      plane_open <= 1'b0;
      last_block <= '0;
      last_page <= '0;
      last_valid <= 1'b0;
      bad_block <= '0;
      bad_valid <= 1'b0;
      err <= 1'b0;
      rd_valid <= 1'b0;
      rd_data <= 8'h00;
      op_done <= 1'b0;
      op_error <= 1'b0;
      op_status <= 8'h00;
    end else begin
      rd_valid <= 1'b0;
      op_done <= 1'b0;
      unique case (state)
        NFHC_IDLE: begin
          if (accept) begin
            op <= nfhc_op_t'(req_op);
            col <= req_col;
            row <= req_row;
            remain <= req_len;
            addr_idx <= 3'd0;
            // Reset skips the confirm step, so the wait counter starts clean here
            wait_cnt <= 23'h0;
            err <= reject;
            state <= reject ? NFHC_DONE : NFHC_CMD1;
            if (!reject && is_prog) begin
              last_block <= req_block;
              last_page <= req_page;
              last_valid <= 1'b1;
            end
            if (!reject && req_op == NFHC_OP_RESET) plane_open <= 1'b0;
          end
        end
        NFHC_CMD1: if (bc_done) begin
          if (op == NFHC_OP_STATUS) state <= NFHC_STAT;
          else if (op == NFHC_OP_RESET) state <= NFHC_WB;
          else state <= NFHC_ADDR;
        end
        NFHC_ADDR: if (bc_done) begin
          addr_idx <= addr_idx + 3'd1;
          if (addr_idx == 3'(ADDR_CYCLES - 1)) begin
            state <= (op == NFHC_OP_READ) ? NFHC_CMD2 : NFHC_WDATA;
          end
        end
        NFHC_WDATA: if (bc_done) begin
          remain <= remain - 12'h001;
          if (last_xfer) state <= NFHC_CMD2;
        end
        NFHC_CMD2: if (bc_done) begin
          plane_open <= (op == NFHC_OP_PLANE_FIRST);
          wait_cnt <= 23'h0;
          state <= NFHC_WB;
        end
        NFHC_WB: begin
          // Busy may not show until tWB after the last strobe
          wait_cnt <= wait_cnt + 23'h1;
          if (wait_cnt == 23'(WB_CYC)) begin
            wait_cnt <= 23'h0;
            state <= NFHC_BUSY;
          end
        end
        NFHC_BUSY: begin
          wait_cnt <= wait_cnt + 23'h1;
          if (rb_sync2) begin
            state <= (op == NFHC_OP_READ) ? NFHC_RDATA : NFHC_DONE;
          end else if (timeout) begin
            err <= 1'b1;
            if (prog_op(op)) begin
              bad_block <= row[ROW_W-1:PAGE_IN_BLOCK_W];
              bad_valid <= 1'b1;
            end
            state <= NFHC_DONE;
          end
        end
        NFHC_RDATA: if (bc_done) begin
          rd_valid <= 1'b1;
          rd_data <= bc_rdata;
          remain <= remain - 12'h001;
          if (last_xfer) state <= NFHC_DONE;
        end
        NFHC_STAT: if (bc_done) begin
          op_status <= bc_rdata;
          state <= NFHC_DONE;
        end
        NFHC_DONE: begin
          op_done <= 1'b1;
          op_error <= err;
          state <= NFHC_IDLE;
        end
        default: state <= NFHC_IDLE;
      endcase
    end
  end
endmodule // nfhc_host
`default_nettype wire

/* File: verif/nfhc_nand_model.sv */
`timescale 1ns/1ps
`default_nettype none
module nfhc_nand_model (
  input wire logic cle,
  input wire logic ale,
  input wire logic ce_n,
  input wire logic we_n,
  input wire logic re_n,
  input wire logic [7:0] io_d,
  input wire logic slow,
  output logic [7:0] io_q,
  output logic rb
);
  logic [7:0] mem [int];
  logic [7:0] pbuf [int];
  logic [7:0] cmd = 8'h00;
  logic [39:0] abuf = 40'h0000000000;
  int acnt, col, row, n_cmd, dbusy, partial;
  initial begin
    rb = 1'b1;
    io_q = 8'h00;
  end
  task automatic busy(input int ns);
    #20 rb = 1'b0;
    #(ns) rb = 1'b1;
  endtask
  // ----------------------------------------
  // Write strobes
  // ----------------------------------------
  // Column position survives chip select going high between bytes
  always @(posedge we_n) begin
    if (!ce_n && cle) begin
      cmd = io_d;
      n_cmd++;
      acnt = 0;
      if (cmd == 8'h30) busy(slow ? 2000 : 400);
      if (cmd == 8'h11) begin
        dbusy++;
        busy(500);
      end
      if (cmd == 8'h10) begin
        // Less than whole sectors would leave the check codes corrupted
        if (pbuf.num() % 16 != 0) partial++;
        foreach (pbuf[k]) mem[k] = pbuf[k];
        pbuf.delete();
        busy(slow ? 6000 : 400);
      end
      if (cmd == 8'hFF) busy(400);
    end else if (!ce_n && ale) begin
      abuf[acnt*8 +: 8] = io_d;
      acnt++;
      col = int'(abuf[11:0]);
      row = int'(abuf[32:16]);
    end else if (!ce_n) begin
      pbuf[row*4096+col] = io_d;
      col++;
    end
  end
  // ----------------------------------------
  // Read strobes
  // ----------------------------------------
  always @(negedge re_n) begin
    // Chip select settles in the same step as the strobe
    #1;
    if (!ce_n && cmd == 8'h70) io_q = 8'hE0;
    else if (!ce_n) begin
      io_q = mem.exists(row*4096+col) ? mem[row*4096+col] : 8'hFF;
      col++;
    end
  end
  // Released bus shows the inverse so a stale byte never passes as data
  always @(posedge re_n) io_q = ~io_q;
endmodule // nfhc_nand_model
`default_nettype wire

/* File: verif/nfhc_host_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module nfhc_host_chk (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic op_done,
  input wire logic op_error,
  input wire logic nand_cle,
  input wire logic nand_ale,
  input wire logic nand_ce_n,
  input wire logic nand_we_n,
  input wire logic nand_re_n,
  input wire logic nand_io_oe,
  input wire logic nand_rb
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // ----------------------------------------
  // Pin protocol
  // ----------------------------------------
  a_idle_after_rst: assert property ($fell(sys_rst) |-> nand_ce_n && nand_we_n && !nand_io_oe)
    else $error("pins not idle after reset");
  a_latch_excl: assert property (!(nand_cle && nand_ale))
    else $error("cle and ale together");
  a_strobe_excl: assert property (!(!nand_we_n && !nand_re_n))
    else $error("we and re low together");
  a_we_width: assert property ($fell(nand_we_n) |-> !nand_we_n [*7])
    else $error("write strobe too short");
  a_busy_quiet: assert property (!nand_rb [*3] |-> nand_we_n && nand_re_n)
    else $error("strobe while busy");
  a_read_no_drive: assert property (!nand_re_n |-> !nand_io_oe)
    else $error("bus driven during read");
  a_sel_strobe: assert property ((!nand_we_n || !nand_re_n) |-> !nand_ce_n)
    else $error("strobe without chip select");
  // ----------------------------------------
  // Request side
  // ----------------------------------------
  a_done_pulse: assert property (op_done |=> !op_done)
    else $error("done longer than one cycle");
  a_ready_drop: assert property (req_valid && req_ready |=> !req_ready)
    else $error("ready stays high after take");
  a_err_with_done: assert property ($changed(op_error) |-> op_done)
    else $error("error flag moved without done");
  c_ok: cover property (op_done && !op_error);
  c_reject: cover property (op_done && op_error);
  c_busy: cover property ($fell(nand_rb));
endmodule // nfhc_host_chk
`default_nettype wire

/* File: verif/test_nfhc_host.sv */
`timescale 1ns/1ps
`default_nettype none
module test_nfhc_host;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic req_valid = 1'b0;
  logic wr_valid = 1'b0;
  logic slow = 1'b0;
  logic req_ready, wr_ready, rd_valid, op_done, op_error;
  logic [2:0] req_op = 3'h0;
  logic [11:0] req_col = 12'h000, req_len = 12'h000;
  logic [16:0] req_row = 17'h00000;
  logic [7:0] wr_data = 8'h00, rd_data, op_status, io_out, io_q;
  logic cle, ale, ce_n, we_n, re_n, io_oe, rb;
  wire [7:0] io_bus = io_oe ? io_out : io_q;
  int n_errors = 0, check_count = 0, n_rd;
  localparam int ROW_A = 32'h00000043;
  nfhc_host #(.BUSY_TIMEOUT_CYC(1000)) nfhc_host_i (.clk_sys, .sys_rst, .req_valid,
    .req_ready, .req_op, .req_col, .req_row, .req_len, .wr_valid, .wr_ready, .wr_data,
    .rd_valid, .rd_data, .op_done, .op_error, .op_status, .nand_cle(cle), .nand_ale(ale),
    .nand_ce_n(ce_n), .nand_we_n(we_n), .nand_re_n(re_n), .nand_io_out(io_out),
    .nand_io_oe(io_oe), .nand_io_in(io_bus), .nand_rb(rb));
  nfhc_nand_model nfhc_nand_model_i (.cle, .ale, .ce_n, .we_n, .re_n, .io_d(io_bus),
    .slow, .io_q, .rb);
  initial begin
    forever #2 clk_sys = ~clk_sys;
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  function automatic logic [7:0] pat(input int c, input int r);
    return 8'(c ^ r) ^ 8'h5A;
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
      n_errors++;
    end
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Entered just after a clock edge; returns just after the edge showing op_done
  task automatic run(input logic [2:0] op, input int c, input int r, input int n);
    int i, t;
    i = 0;
    n_rd = 0;
    req_op = op;
    req_col = 12'(c);
    req_row = 17'(r);
    req_len = 12'(n);
    req_valid = 1'b1;
    for (t = 0; !req_ready && t < 50; t++) @(posedge clk_sys) #1;
    if (!req_ready) begin
      chk("request taken", 0, 1);
      test_done();
    end
    @(posedge clk_sys) #1;
    req_valid = 1'b0;
    for (t = 0; t < 40000 && !op_done; t++) begin
      wr_valid = (op inside {3'h1, 3'h2, 3'h3}) && i < n;
      wr_data = pat(c + i, r);
      #1;
      if (wr_valid && wr_ready) i++;
      @(posedge clk_sys) #1;
      if (rd_valid && op == 3'h0) begin
        chk("read byte", rd_data, pat(c + n_rd, r));
        n_rd++;
      end
    end
    wr_valid = 1'b0;
    if (t == 40000) begin
      chk("request completion", 0, 1);
      test_done();
    end
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic s_page;
    run(3'h1, 0, ROW_A, 2112);
    chk("page program", op_error, 0);
    chk("address row", nfhc_nand_model_i.row, ROW_A);
    chk("last byte", nfhc_nand_model_i.mem[ROW_A*4096+2111], pat(2111, ROW_A));
    run(3'h0, 2040, ROW_A, 12);
    chk("bytes read", n_rd, 12);
  endtask
  task automatic s_slow;
    slow = 1'b1;
    run(3'h0, 2048, ROW_A, 4);
    chk("slow read", op_error, 0);
    chk("slow bytes", n_rd, 4);
    slow = 1'b0;
  endtask
  task automatic s_sector;
    int n;
    run(3'h1, 512, ROW_A + 1, 512);
    chk("sector main", op_error, 0);
    run(3'h1, 2080, ROW_A + 2, 16);
    chk("sector spare", op_error, 0);
    run(3'h0, 2080, ROW_A + 2, 16);
    chk("spare bytes", n_rd, 16);
    n = nfhc_nand_model_i.n_cmd;
    run(3'h1, 100, ROW_A + 3, 16);
    chk("misaligned sector", op_error, 1);
    run(3'h1, 0, ROW_A + 3, 200);
    chk("partial sector", op_error, 1);
    chk("pins quiet", nfhc_nand_model_i.n_cmd, n);
    chk("whole sectors", nfhc_nand_model_i.partial, 0);
  endtask
  task automatic s_order;
    int n;
    n = nfhc_nand_model_i.n_cmd;
    run(3'h1, 2096, ROW_A - 1, 16);
    chk("descending page", op_error, 1);
    run(3'h1, 2096, ROW_A + 2, 16);
    chk("repeated page", op_error, 1);
    chk("pins quiet", nfhc_nand_model_i.n_cmd, n);
    run(3'h1, 2096, 32'h00000089, 16);
    chk("new block floor", op_error, 0);
  endtask
  task automatic s_plane;
    int n, d;
    d = nfhc_nand_model_i.dbusy;
    run(3'h2, 2048, 32'h00000100, 16);
    chk("first plane", op_error, 0);
    chk("dummy busy", nfhc_nand_model_i.dbusy, d + 1);
    n = nfhc_nand_model_i.n_cmd;
    run(3'h0, 0, ROW_A, 4);
    chk("read between planes", op_error, 1);
    chk("pins quiet", nfhc_nand_model_i.n_cmd, n);
    run(3'h4, 0, 0, 0);
    chk("status", op_status, 8'hE0);
    run(3'h3, 2048, 32'h00000140, 16);
    chk("second plane", op_error, 0);
    run(3'h0, 2048, 32'h00000140, 16);
    chk("plane bytes", n_rd, 16);
    run(3'h5, 0, 0, 0);
    chk("reset", op_error, 0);
  endtask
  task automatic s_bad;
    int n, t;
    slow = 1'b1;
    run(3'h1, 2048, 32'h000001C5, 16);
    chk("program failure", op_error, 1);
    for (t = 0; t < 2000 && !rb; t++) @(posedge clk_sys) #1;
    chk("device ready", rb, 1);
    slow = 1'b0;
    n = nfhc_nand_model_i.n_cmd;
    run(3'h1, 2048, 32'h000001C6, 16);
    chk("failed block refused", op_error, 1);
    chk("pins quiet", nfhc_nand_model_i.n_cmd, n);
    run(3'h1, 2048, 32'h00000205, 16);
    chk("replacement page", op_error, 0);
  endtask
  initial begin
    repeat (2) @(posedge clk_sys);
    #1;
    sys_rst = 1'b0;
    s_page();
    s_slow();
    s_sector();
    s_order();
    s_plane();
    s_bad();
    test_done();
  end
endmodule // test_nfhc_host
bind nfhc_host nfhc_host_chk nfhc_host_chk_i (.clk_sys, .sys_rst, .req_valid, .req_ready,
  .op_done, .op_error, .nand_cle, .nand_ale, .nand_ce_n, .nand_we_n, .nand_re_n,
  .nand_io_oe, .nand_rb);
`default_nettype wire
